// >>> rtl/seq_pkg.sv
// Constants, carriers and register layout for the sequential LED switch sequencer
// How it works
// - A whole animation is one step per active switch, each one step period long.
// - Pin codes are captured once at power-up; step period is measured continuously.
// - Startup order: supply up, sample pins, bias on, then release enable.
// - Switches take the initial state; each step end flips the next switch.
// - After the last step all switches hold until supply or enable toggles.
// - Chain position comes from the 4-bit chain position code, sixteen positions.
// - The chain advances on each low-to-high transition of the handoff line.
// - A running device pulls the handoff line low and releases it when done.
// - Position zero starts on enable; position N waits for N handoff pulses.
// - Each configuration pin gives one of sixteen levels, a 4-bit value.
// - Low three threshold bits choose one of eight short LED thresholds.
// - Dim down starts all active switches open, then closes one by one from the highest active switch.
// - Dim up starts all closed, then opens one by one until all active switches are open.
// - Low two switch bits choose switches 123, 1245, 12345 or all six.
// - Unused switches stay closed while enable is high.
// - Upper two switch bits give no fade or a fade of 1, 2 or 3 periods.
// - Fade pulses grow by 1.0625 when dimming up, shrink by 0.9375 when down.
// - Fade PWM frequency in kHz is 75 over fade length times step period.
// - Enable is an input and an open-drain output held low until ready.
// - While enable is low all switches stay open and nothing sequences.
package seq_pkg;

  localparam int NUM_SW = 6;
  localparam int PER_W  = 24;

  typedef struct packed {
    logic [3:0] switch_fade_select_pin;
    logic [3:0] chain_position_pin;
    logic [3:0] threshold_direction_pin;
  } cfg_t;

  typedef enum logic [2:0] {
    ST_POR    = 3'b000,
    ST_SAMPLE = 3'b001,
    ST_BIAS   = 3'b010,
    ST_READY  = 3'b011,
    ST_WAIT   = 3'b100,
    ST_RUN    = 3'b101,
    ST_DONE   = 3'b110
  } seq_state_t;

  // Active switch sets, bit 0 is switch one
  localparam logic [5:0] MASK_SW3 = 6'h07;
  localparam logic [5:0] MASK_SW4 = 6'h1b;
  localparam logic [5:0] MASK_SW5 = 6'h1f;
  localparam logic [5:0] MASK_SW6 = 6'h3f;
  localparam logic [2:0] SW_COUNT_BASE = 3'h3;

  // Fade: 75 PWM periods per fade, duty in Q16
  localparam logic [6:0]  FADE_PWM_STEPS = 7'h4b;
  localparam logic [15:0] DUTY_UP_START  = 16'h02b9;
  localparam logic [15:0] DUTY_FULL      = 16'hffff;
  localparam int          DUTY_SHIFT     = 4;

  // Register map, byte addresses
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_CONFIG = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_PERIOD = 8'h0c;
  localparam int         CTRL_HOLD_BIT   = 0;
  localparam logic       CTRL_HOLD_RESET = 1'h0;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : seq_pkg

// >>> rtl/fade_pwm.sv
// Logarithmic fade PWM for the switch in transition
`timescale 1ns/1ps
module fade_pwm #(
  parameter int PER_W = seq_pkg::PER_W
) (
  input  wire logic             sys_clk_i,
  input  wire logic             rst_i,
  input  wire logic             start_i,
  input  wire logic             clear_i,
  input  wire logic             dim_up_i,
  input  wire logic [1:0]       fade_len_i,
  input  wire logic [PER_W-1:0] period_i,
  output logic                  active_o,
  output logic                  open_o
);
  import seq_pkg::*;

  logic [PER_W+1:0]  span;
  logic [PER_W+1:0]  acc_reg;
  logic [PER_W+1:0]  acc_plus;
  logic [PER_W+1:0]  acc_next;
  logic [PER_W+1:0]  thr;
  logic [PER_W+17:0] prod;
  logic [15:0]       duty_reg;
  logic [15:0]       duty_next;
  logic [15:0]       duty_step;
  logic [16:0]       duty_grow;
  logic [6:0]        cnt_reg;
  logic [6:0]        cnt_next;
  logic              active_reg;
  logic              active_next;
  logic              open_reg;
  logic              open_next;
  logic              wrap;
  logic              last;

  // 75 accumulator wraps per fade span: PWM rate tracks the step period
  assign span     = (PER_W+2)'(period_i) * (PER_W+2)'(fade_len_i);
  assign acc_plus = acc_reg + (PER_W+2)'(FADE_PWM_STEPS);
  assign wrap     = (acc_plus >= span);
  assign acc_next = start_i ? '0 : (wrap ? acc_plus - span : acc_plus);
  assign last     = (cnt_reg == FADE_PWM_STEPS - 7'h01);

  // Geometric pulse growth or shrink by one sixteenth
  assign duty_grow = {1'b0, duty_reg} + {1'b0, duty_reg >> DUTY_SHIFT};
  assign duty_step = dim_up_i ? (duty_grow[16] ? DUTY_FULL : duty_grow[15:0])
                              : duty_reg - (duty_reg >> DUTY_SHIFT);
  assign duty_next = start_i ? (dim_up_i ? DUTY_UP_START : DUTY_FULL)
                   : (active_reg && wrap) ? duty_step : duty_reg;
  assign cnt_next  = start_i ? '0 : (active_reg && wrap) ? cnt_reg + 7'h01 : cnt_reg;

  assign active_next = clear_i ? 1'b0 : start_i ? 1'b1
                     : (active_reg && wrap && last) ? 1'b0 : active_reg;

  assign prod      = {(PER_W+2)'(0), duty_reg} * {16'h0000, span};
  assign thr       = prod[PER_W+17:16];
  assign open_next = active_next && (acc_next < thr);

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      acc_reg    <= '0;
      duty_reg   <= '0;
      cnt_reg    <= '0;
      active_reg <= 1'b0;
      open_reg   <= 1'b0;
    end else begin
      acc_reg    <= acc_next;
      duty_reg   <= duty_next;
      cnt_reg    <= cnt_next;
      active_reg <= active_next;
      open_reg   <= open_next;
    end
  end

  assign active_o = active_reg;
  assign open_o   = open_reg;

endmodule : fade_pwm

// >>> rtl/led_sequencer.sv
// Sequencing core: startup, chain handoff, switch stepping, fade and register slave
`timescale 1ns/1ps
module led_sequencer #(
  parameter int ADDR_W = 8,
  parameter int PER_W  = seq_pkg::PER_W
) (
  input  wire logic              sys_clk_i,
  input  wire logic              rst_i,
  // Power-up and bias
  input  wire logic              supply_ok_i,
  input  wire seq_pkg::cfg_t     cfg_pins_i,
  input  wire logic              bias_ready_i,
  output logic                   bias_en_o,
  // Enable line, open drain
  input  wire logic              en_i,
  output logic                   en_o,
  output logic                   en_oe_o,
  // Chain handoff line, open drain
  input  wire logic              sync_i,
  output logic                   sync_o,
  output logic                   sync_oe_o,
  // Step oscillator tick
  input  wire logic              step_tick_i,
  // Switch drive, 1 = closed
  output logic [5:0]             switch_closed_o,
  output logic [2:0]             short_led_threshold_o,
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);
  import seq_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  seq_state_t       state_reg;
  seq_state_t       state_next;
  cfg_t             cfg_reg;
  logic [5:0]       changed_reg;
  logic [5:0]       changed_next;
  logic [2:0]       step_cnt_reg;
  logic [2:0]       step_cnt_next;
  logic [3:0]       edge_cnt_reg;
  logic [3:0]       edge_cnt_next;
  logic             sync_prev_reg;
  logic [PER_W-1:0] per_cnt_reg;
  logic [PER_W-1:0] period_reg;
  logic [2:0]       fade_idx_reg;
  logic [5:0]       switch_closed_reg;
  logic [5:0]       switch_closed_next;
  logic             hold_reg;

  logic [5:0]       active_mask;
  logic [2:0]       sw_count;
  logic [1:0]       fade_len;
  logic [3:0]       position;
  logic             dim_up;
  logic             en_ready;
  logic             enabled;
  logic             sync_rise;
  logic             step_en;
  logic             last_step;
  logic             fade_start;
  logic             fade_active;
  logic             fade_open;
  logic [5:0]       pending;
  logic [5:0]       sel_oh;
  logic [2:0]       sel_idx;
  logic             chain_go;

  // ----------------------------------------------------------------
  // Configuration decode
  // ----------------------------------------------------------------
  // Codes only change in the sample state, so the decode is stable after
  assign dim_up   = cfg_reg.threshold_direction_pin[3];
  assign position = cfg_reg.chain_position_pin;
  assign fade_len = cfg_reg.switch_fade_select_pin[3:2];
  assign sw_count = SW_COUNT_BASE + {1'b0, cfg_reg.switch_fade_select_pin[1:0]};

  assign active_mask = (cfg_reg.switch_fade_select_pin[1:0] == 2'b00) ? MASK_SW3 :
                       (cfg_reg.switch_fade_select_pin[1:0] == 2'b01) ? MASK_SW4 :
                       (cfg_reg.switch_fade_select_pin[1:0] == 2'b10) ? MASK_SW5 :
                       MASK_SW6;

  // ----------------------------------------------------------------
  // Enable line and handoff line
  // ----------------------------------------------------------------
  // Enable is pulled low until startup has finished, so the LED driver
  // tied to it cannot source current into an unprepared string
  assign en_ready  = (state_reg == ST_READY) || (state_reg == ST_WAIT) ||
                     (state_reg == ST_RUN) || (state_reg == ST_DONE);
  assign en_o      = 1'b0;
  assign en_oe_o   = !en_ready;
  assign enabled   = en_ready && en_i && supply_ok_i;

  assign sync_o    = 1'b0;
  assign sync_oe_o = (state_reg == ST_RUN);
  assign sync_rise = sync_i && !sync_prev_reg;

  assign bias_en_o = (state_reg != ST_POR) && (state_reg != ST_SAMPLE);

  // Wait state ends when the pulse count reaches the chain position
  assign chain_go  = (state_reg == ST_WAIT) && sync_rise &&
                     ((edge_cnt_reg + 4'h1) == position);
  assign edge_cnt_next = !enabled ? '0
                       : ((state_reg == ST_WAIT) && sync_rise) ? edge_cnt_reg + 4'h1
                       : edge_cnt_reg;

  // ----------------------------------------------------------------
  // Step selection
  // ----------------------------------------------------------------
  // Hold from software freezes stepping but not period tracking
  assign step_en   = (state_reg == ST_RUN) && enabled && step_tick_i && !hold_reg;
  assign last_step = (step_cnt_reg == sw_count - 3'h1);
  assign pending   = active_mask & ~changed_reg;

  // Dim down walks from the highest active switch downward, dim up from switch one upward
  always_comb begin
    int idx;
    idx     = 0;
    sel_oh  = '0;
    sel_idx = '0;
    for (int k = 0; k < NUM_SW; k++) begin
      idx = dim_up ? (NUM_SW - 1 - k) : k;
      if (pending[idx]) begin
        sel_oh  = 6'(1 << idx);
        sel_idx = 3'(idx);
      end
    end
  end

  assign changed_next  = !enabled ? '0
                       : step_en ? (changed_reg | sel_oh) : changed_reg;
  assign step_cnt_next = !enabled ? '0
                       : step_en ? step_cnt_reg + 3'h1 : step_cnt_reg;
  assign fade_start    = step_en && (fade_len != 2'b00);

  // ----------------------------------------------------------------
  // Startup and sequence state machine
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_POR: begin
        if (supply_ok_i) begin
          state_next = ST_SAMPLE;
        end
      end
      ST_SAMPLE: begin
        state_next = ST_BIAS;
      end
      ST_BIAS: begin
        if (bias_ready_i) begin
          state_next = ST_READY;
        end
      end
      ST_READY: begin
        if (enabled) begin
          state_next = (position == 4'h0) ? ST_RUN : ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (chain_go) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (step_en && last_step) begin
          state_next = ST_DONE;
        end
      end
      ST_DONE: begin
        state_next = ST_DONE;
      end
      default: begin
        state_next = ST_POR;
      end
    endcase
    // Toggling enable restarts the animation; losing supply restarts all
    if (en_ready && !en_i) begin
      state_next = ST_READY;
    end
    if (!supply_ok_i) begin
      state_next = ST_POR;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg     <= ST_POR;
      changed_reg   <= '0;
      step_cnt_reg  <= '0;
      edge_cnt_reg  <= '0;
      sync_prev_reg <= 1'b1;
    end else begin
      state_reg     <= state_next;
      changed_reg   <= changed_next;
      step_cnt_reg  <= step_cnt_next;
      edge_cnt_reg  <= edge_cnt_next;
      sync_prev_reg <= sync_i;
    end
  end

  // Pin codes are taken in the sample state only
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_reg <= '0;
    end else if (state_reg == ST_SAMPLE) begin
      cfg_reg <= cfg_pins_i;
    end
  end

  // ----------------------------------------------------------------
  // Step period tracking
  // ----------------------------------------------------------------
  // Measured on every tick, so a changed oscillator rate takes effect
  // within one step; the counter saturates for very slow settings
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      per_cnt_reg <= '0;
      period_reg  <= '0;
    end else if (step_tick_i) begin
      per_cnt_reg <= '0;
      period_reg  <= (&per_cnt_reg) ? per_cnt_reg : per_cnt_reg + PER_W'(1);
    end else if (!(&per_cnt_reg)) begin
      per_cnt_reg <= per_cnt_reg + PER_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // Fade
  // ----------------------------------------------------------------
  // A new step restarts the fade, so an earlier switch snaps to its final
  // state when fades overlap
  fade_pwm #(
    .PER_W(PER_W)
  ) u_fade (
    .sys_clk_i  (sys_clk_i),
    .rst_i      (rst_i),
    .start_i    (fade_start),
    .clear_i    (!enabled),
    .dim_up_i   (dim_up),
    .fade_len_i (fade_len),
    .period_i   (period_reg),
    .active_o   (fade_active),
    .open_o     (fade_open)
  );

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      fade_idx_reg <= '0;
    end else if (fade_start) begin
      fade_idx_reg <= sel_idx;
    end
  end

  // ----------------------------------------------------------------
  // Switch drive
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_SW; g++) begin : g_sw
      assign switch_closed_next[g] =
        !enabled                                      ? 1'b0 :
        !active_mask[g]                               ? 1'b1 :
        (fade_active && (fade_idx_reg == 3'(g)))      ? !fade_open :
        (changed_reg[g] ^ dim_up);
    end
  endgenerate

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      switch_closed_reg <= '0;
    end else begin
      switch_closed_reg <= switch_closed_next;
    end
  end

  assign switch_closed_o       = switch_closed_reg;
  assign short_led_threshold_o = cfg_reg.threshold_direction_pin[2:0];

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        rvalid_reg;
  logic [1:0]  rresp_reg;
  logic [31:0] rdata_reg;
  logic        wr_take;
  logic        rd_take;
  logic        wr_ctrl;
  logic        wr_mapped;
  logic        rd_mapped;
  logic [31:0] rd_mux;
  logic [7:0]  wr_word;
  logic [7:0]  rd_word;

  // Address and data are taken together once both are offered
  assign wr_take   = s_axi_awvalid && s_axi_wvalid && !bvalid_reg;
  assign rd_take   = s_axi_arvalid && !rvalid_reg;
  assign wr_word   = {8'(s_axi_awaddr) & 8'hfc};
  assign rd_word   = {8'(s_axi_araddr) & 8'hfc};
  assign wr_ctrl   = (wr_word == ADDR_CTRL);
  assign wr_mapped = wr_ctrl || (wr_word == ADDR_CONFIG) ||
                     (wr_word == ADDR_STATUS) || (wr_word == ADDR_PERIOD);
  assign rd_mapped = (rd_word == ADDR_CTRL) || (rd_word == ADDR_CONFIG) ||
                     (rd_word == ADDR_STATUS) || (rd_word == ADDR_PERIOD);

  assign rd_mux = (rd_word == ADDR_CTRL)   ? {31'h0000_0000, hold_reg} :
                  (rd_word == ADDR_CONFIG) ? {20'h0_0000, cfg_reg} :
                  (rd_word == ADDR_STATUS) ? {14'h0000, fade_active, sync_oe_o,
                                              switch_closed_reg,
                                              edge_cnt_reg, step_cnt_reg, state_reg} :
                  (rd_word == ADDR_PERIOD) ? 32'(period_reg) :
                  32'h0000_0000;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
      hold_reg   <= CTRL_HOLD_RESET;
    end else if (wr_take) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      if (wr_ctrl && s_axi_wstrb[0]) begin
        hold_reg <= s_axi_wdata[CTRL_HOLD_BIT];
      end
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rvalid_reg <= 1'b0;
      rresp_reg  <= RESP_OKAY;
      rdata_reg  <= '0;
    end else if (rd_take) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      rdata_reg  <= rd_mux;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign s_axi_awready = wr_take;
  assign s_axi_wready  = wr_take;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = rd_take;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = rdata_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  AST_EN_HELD_LOW: assert property (
    (state_reg == ST_POR || state_reg == ST_SAMPLE || state_reg == ST_BIAS) |-> en_oe_o)
    else $error("enable released before startup finished");

  AST_STARTUP_ORDER: assert property (
    (state_reg == ST_SAMPLE) |=> (state_reg == ST_BIAS || state_reg == ST_POR) && bias_en_o == $past(supply_ok_i))
    else $error("bias not powered right after sampling");

  AST_EN_LOW_OPEN: assert property (
    (!en_i) |=> (switch_closed_o == 6'h00))
    else $error("switch closed while enable low");

  AST_UNUSED_CLOSED: assert property (
    enabled |=> ((switch_closed_o | active_mask) == 6'h3f))
    else $error("unused switch not closed");

  AST_ONE_FLIP: assert property (
    step_en |=> ($countones(changed_reg ^ $past(changed_reg)) == 1))
    else $error("step did not change exactly one switch");

  AST_NO_TICK_NO_STEP: assert property (
    (state_reg == ST_RUN && enabled && !step_tick_i) |=> $stable(changed_reg))
    else $error("switch changed without a step tick");

  AST_DONE_ALL: assert property (
    (state_reg == ST_DONE) |-> (changed_reg == active_mask && step_cnt_reg == sw_count))
    else $error("sequence ended with wrong step count");

  AST_SYNC_RELEASE: assert property (
    (step_en && last_step && supply_ok_i) |=> (!sync_oe_o && state_reg == ST_DONE))
    else $error("handoff line not released at sequence end");

  AST_CFG_STABLE: assert property (
    (state_reg != ST_POR && state_reg != ST_SAMPLE) |=> $stable(cfg_reg))
    else $error("configuration changed after sampling");

  AST_ZERO_STARTS: assert property (
    (state_reg == ST_READY && enabled && position == 4'h0) |=> (state_reg == ST_RUN))
    else $error("position zero did not start on enable");

  AST_WAIT_BELOW: assert property (
    (state_reg == ST_WAIT) |-> (edge_cnt_reg < position))
    else $error("waiting device counted past its position");

  AST_DIR_INIT: assert property (
    (enabled && changed_reg == 6'h00 && !fade_active) |=> (switch_closed_o == (dim_up ? 6'h3f : ~active_mask)))
    else $error("initial switch state wrong for direction");

endmodule : led_sequencer

// >>> test/peer_model.sv
// Peer sequencer on the shared open-drain handoff line
`timescale 1ns/1ps
module peer_model (
  input  wire logic sys_clk_i,
  input  wire logic go_i,
  output logic      pull_o
);
  logic [3:0] cnt_reg = 4'h0;
  always_ff @(posedge sys_clk_i) begin
    if (go_i) cnt_reg <= 4'h8;
    else if (cnt_reg != 4'h0) cnt_reg <= cnt_reg - 4'h1;
  end
  // Holds the line low while its own run lasts, then lets the pull-up raise it
  assign pull_o = (cnt_reg != 4'h0);
endmodule : peer_model

// >>> test/tb.sv
// Self-checking bench for the LED switch sequencer
`timescale 1ns/1ps
module tb;
  import seq_pkg::*;
  logic sys_clk_i = 0, rst_i = 1, supply_ok_i = 0, bias_ready_i = 0, en_host = 0, step_tick_i = 0, peer_go = 0;
  cfg_t cfg_pins_i = 12'h000;
  logic bias_en_o, en_o, en_oe_o, sync_o, sync_oe_o, peer_pull, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [5:0] sw;
  logic [2:0] short_led_threshold_o;
  int n_fail = 0, n_tests = 0, n_closed = 0;
  logic [5:0] sw_seq [6] = '{6'h3e, 6'h3c, 6'h38, 6'h30, 6'h20, 6'h00};
  // Enable has a pull-down, the handoff line a pull-up
  wire en_i = en_host & ~en_oe_o;
  wire sync_i = ~(sync_oe_o | peer_pull);
  always #5 sys_clk_i = ~sys_clk_i;
  led_sequencer DUT (.sys_clk_i, .rst_i, .supply_ok_i, .cfg_pins_i, .bias_ready_i, .bias_en_o, .en_i, .en_o,
    .en_oe_o, .sync_i, .sync_o, .sync_oe_o, .step_tick_i, .switch_closed_o(sw), .short_led_threshold_o,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  peer_model peer (.sys_clk_i, .go_i(peer_go), .pull_o(peer_pull));
  task automatic end_sim;
    $display("tests %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_sim
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge sys_clk_i);
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
    for (i = 0; i < 50; i++) begin
      @(posedge sys_clk_i);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 0;
    check(s_axi_bresp, RESP_OKAY);
    if (i == 50) begin n_fail++; end_sim(); end
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    int i;
    @(posedge sys_clk_i);
    s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
    for (i = 0; i < 50; i++) begin
      @(posedge sys_clk_i);
      if (s_axi_arready) s_axi_arvalid <= 0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 0;
    check(s_axi_rdata, exp);
    check(s_axi_rresp, er);
    if (i == 50) begin n_fail++; end_sim(); end
  endtask : rd
  task automatic pulse;
    @(posedge sys_clk_i); step_tick_i <= 1;
    @(posedge sys_clk_i); step_tick_i <= 0;
  endtask : pulse
  task automatic tick(input logic [5:0] exp);
    pulse();
    cyc(3); check(sw, exp);
  endtask : tick
  task automatic boot(input logic [11:0] c);
    supply_ok_i <= 0; en_host <= 0; bias_ready_i <= 0; cfg_pins_i <= c;
    cyc(4); supply_ok_i <= 1;
    cyc(5); check(bias_en_o, 1); check(en_oe_o, 1); check(en_o, 0);
    bias_ready_i <= 1;
    cyc(4); check(en_oe_o, 0);
    cfg_pins_i <= ~c; // Later pin moves must not reach the configuration
    rd(ADDR_CONFIG, {20'h0, c}, RESP_OKAY);
    check(short_led_threshold_o, c[2:0]); check(sw, 0);
  endtask : boot
  initial begin
    cyc(16); rst_i <= 0;
    boot(12'h308);
    wr(ADDR_CTRL, 0);
    en_host <= 1; cyc(3); check(sw, 6'h3f); check(sync_oe_o, 1); check(sync_o, 0);
    foreach (sw_seq[k]) tick(sw_seq[k]);
    cyc(2); check(sync_oe_o, 0); tick(6'h00);
    en_host <= 0; cyc(3); check(sw, 0);
    rd(8'h40, 0, RESP_SLVERR);
    boot(12'h027);
    en_host <= 1; cyc(3); check(sync_oe_o, 0);
    peer_go <= 1; cyc(1); peer_go <= 0; cyc(12); check(sync_oe_o, 0);
    peer_go <= 1; cyc(1); peer_go <= 0; cyc(12);
    check(sync_oe_o, 1); check(sw, 6'h38);
    tick(6'h3c); wr(ADDR_CTRL, 1); rd(ADDR_CTRL, 1, RESP_OKAY); tick(6'h3c); wr(ADDR_CTRL, 0);
    tick(6'h3e); tick(6'h3f);
    // Fade over one step period on three switches, dimming up, ticks 100 clocks apart
    boot(12'h408);
    tick(6'h00); cyc(95);
    en_host <= 1; pulse();
    repeat (20) begin @(posedge sys_clk_i); if (sw[0] === 1'b1) n_closed++; end
    check(n_closed >= 10, 1);
    cyc(120); check(sw, 6'h3e);
    rd(ADDR_STATUS, 32'h0001_f80d, RESP_OKAY);
    rd(ADDR_PERIOD, 32'h0000_0064, RESP_OKAY);
    end_sim();
  end
endmodule : tb
